/* File: core/abx_map.svh */
/*
  Register offsets, field positions, opcodes and reset values of the
  and/branch/bit-clear execution block.
  Assumes inclusion by bare name from the core module and the testbench.
*/
`ifndef ABX_MAP_SVH
`define ABX_MAP_SVH

// Wishbone byte offsets
`define ABX_OFF_INSTR   8'h00
`define ABX_OFF_ACC     8'h04
`define ABX_OFF_STATUS  8'h08
`define ABX_OFF_BANK    8'h0C
`define ABX_OFF_PC      8'h10
`define ABX_OFF_CTRL    8'h14
`define ABX_OFF_IDXBASE 8'h18
`define ABX_OFF_FADDR   8'h1C
`define ABX_OFF_FDATA   8'h20

// Status bit positions
`define ABX_ST_C        0
`define ABX_ST_Z        2
`define ABX_ST_N        4
`define ABX_ST_BUSY     8
// Control bit positions
`define ABX_CTRL_EXT    0

// Opcode patterns
`define ABX_OPC_AND_LIT  8'h0B
`define ABX_OPC_AND_FILE 6'h05
`define ABX_OPC_BRC      8'hE2
`define ABX_OPC_BCLR     4'h9

// Addressing
`define ABX_ACCESS_SPLIT 8'h5F
`define ABX_ACCESS_HIGH  4'hF
`define ABX_PC_STEP      21'h000002

// Reset values
`define ABX_RST_INSTR   16'h0000
`define ABX_RST_ACC     8'h00
`define ABX_RST_STATUS  8'h00
`define ABX_RST_BANK    4'h0
`define ABX_RST_PC      21'h000000
`define ABX_RST_CTRL    1'b0
`define ABX_RST_IDXBASE 12'h000
`define ABX_RST_FADDR   12'h000

`endif

/* File: core/abx_pkg.sv */
/*
  Types of the and/branch/bit-clear execution block.
  Assumes nothing beyond a SystemVerilog compiler.
*/
package abx_pkg;
  typedef enum logic [3:0] {
    ABX_ST_IDLE, ABX_ST_Q1, ABX_ST_Q2, ABX_ST_Q3, ABX_ST_Q4,
    ABX_ST_N1, ABX_ST_N2, ABX_ST_N3, ABX_ST_N4
  } abx_state_e;

  typedef enum logic [2:0] {
    ABX_OP_NONE, ABX_OP_AND_LIT, ABX_OP_AND_FILE, ABX_OP_BRC, ABX_OP_BCLR
  } abx_op_e;
endpackage

/* File: core/abx_core.sv */
/*
  Execution core for and_literal_to_acc, and_acc_with_file,
  branch_on_carry_set and file_bit_clear, reached over classic Wishbone.
  Assumes one clock, a synchronous reset and a well-behaved bus master.
*/
// The register offsets and the Wishbone slave port were decided locally.
// Operation
// - and_acc_with_file ANDs accumulator and file, N Z
// - Destination bit 0 accumulator, 1 file register
// - Access bit 1 uses bank select register
// - Extended set, access bit 0, f<=5Fh indexed
// - branch_on_carry_set branches on carry, flags untouched
// - Target is incremented pc plus twice offset
// - Taken branch two cycles, untaken one cycle
// - file_bit_clear clears indexed bit, flags untouched
`timescale 1ns/1ns
`include "abx_map.svh"

module abx_core (
  // Clock and reset
  input  wire logic        clk,
  input  wire logic        srst,
  // Wishbone slave
  input  wire logic [7:0]  wb_adr_i,
  input  wire logic [31:0] wb_dat_i,
  output logic      [31:0] wb_dat_o,
  input  wire logic        wb_we_i,
  input  wire logic [3:0]  wb_sel_i,
  input  wire logic        wb_stb_i,
  input  wire logic        wb_cyc_i,
  output logic             wb_ack_o,
  // Status
  output logic             exec_busy
);
  import abx_pkg::*;

  abx_state_e  state_ff;
  logic [15:0] instr_ff;
  logic [7:0]  acc_ff;
  logic [7:0]  status_ff;
  logic [3:0]  bank_ff;
  logic [20:0] pc_ff;
  logic        ext_ff;
  logic [11:0] idxbase_ff;
  logic [11:0] faddr_ff;
  logic [7:0]  operand_ff;
  logic [7:0]  result_ff;
  logic        ack_ff;
  logic [31:0] dat_ff;
  logic [7:0]  file_mem [0:4095];

  logic        bus_req;
  logic        sw_wr;
  abx_op_e     op;
  logic [11:0] fa;
  logic        taken;
  logic [20:0] nxt_target;
  logic [31:0] rd_mux;

  function automatic abx_op_e decode(input logic [15:0] ins);
    if (ins[15:8] == `ABX_OPC_AND_LIT) begin
      return ABX_OP_AND_LIT;
    end else if (ins[15:10] == `ABX_OPC_AND_FILE) begin
      return ABX_OP_AND_FILE;
    end else if (ins[15:8] == `ABX_OPC_BRC) begin
      return ABX_OP_BRC;
    end else if (ins[15:12] == `ABX_OPC_BCLR) begin
      return ABX_OP_BCLR;
    end
    return ABX_OP_NONE;
  endfunction

  // Byte-lane merge so partial writes leave other lanes alone
  function automatic logic [31:0] merge(input logic [31:0] old, input logic [31:0] nw,
                                        input logic [3:0] sel);
    logic [31:0] m;
    m = old;
    for (int i = 0; i < 4; i++) begin
      if (sel[i]) begin
        m[i*8 +: 8] = nw[i*8 +: 8];
      end
    end
    return m;
  endfunction

  assign bus_req   = wb_cyc_i & wb_stb_i & ~ack_ff;
  // Core state is frozen for software while an instruction runs
  assign sw_wr     = bus_req & wb_we_i & (state_ff == ABX_ST_IDLE);
  assign exec_busy = (state_ff != ABX_ST_IDLE);
  assign wb_ack_o  = ack_ff;
  assign wb_dat_o  = dat_ff;
  assign op        = decode(instr_ff);
  assign taken     = (op == ABX_OP_BRC) && status_ff[`ABX_ST_C];
  assign nxt_target = pc_ff + {{12{instr_ff[7]}}, instr_ff[7:0], 1'b0};

  always_comb begin
    if (instr_ff[8]) begin
      fa = {bank_ff, instr_ff[7:0]};
    end else if (ext_ff && instr_ff[7:0] <= `ABX_ACCESS_SPLIT) begin
      fa = idxbase_ff + {4'h0, instr_ff[7:0]};
    end else if (instr_ff[7:0] <= `ABX_ACCESS_SPLIT) begin
      fa = {4'h0, instr_ff[7:0]};
    end else begin
      fa = {`ABX_ACCESS_HIGH, instr_ff[7:0]};
    end
  end

  // Sequencer: four phases per instruction cycle
  always_ff @(posedge clk) begin
    if (srst) begin
      state_ff <= ABX_ST_IDLE;
    end else begin
      case (state_ff)
        ABX_ST_IDLE: begin
          if (sw_wr && wb_adr_i == `ABX_OFF_INSTR && wb_sel_i[1:0] == 2'h3) begin
            state_ff <= ABX_ST_Q1;
          end
        end
        ABX_ST_Q1: state_ff <= ABX_ST_Q2;
        ABX_ST_Q2: state_ff <= ABX_ST_Q3;
        ABX_ST_Q3: state_ff <= ABX_ST_Q4;
        ABX_ST_Q4: state_ff <= taken ? ABX_ST_N1 : ABX_ST_IDLE;
        ABX_ST_N1: state_ff <= ABX_ST_N2;
        ABX_ST_N2: state_ff <= ABX_ST_N3;
        ABX_ST_N3: state_ff <= ABX_ST_N4;
        ABX_ST_N4: state_ff <= ABX_ST_IDLE;
        default:   state_ff <= ABX_ST_IDLE;
      endcase
    end
  end

  always_ff @(posedge clk) begin
    if (srst) begin
      instr_ff <= `ABX_RST_INSTR;
    end else if (sw_wr && wb_adr_i == `ABX_OFF_INSTR && wb_sel_i[1:0] == 2'h3) begin
      instr_ff <= wb_dat_i[15:0];
    end
  end

  // Operand read in Q2, result formed in Q3
  always_ff @(posedge clk) begin
    if (srst) begin
      operand_ff <= 8'h00;
      result_ff  <= 8'h00;
    end else if (state_ff == ABX_ST_Q2) begin
      operand_ff <= file_mem[fa];
    end else if (state_ff == ABX_ST_Q3) begin
      case (op)
        ABX_OP_AND_LIT:  result_ff <= acc_ff & instr_ff[7:0];
        ABX_OP_AND_FILE: result_ff <= acc_ff & operand_ff;
        ABX_OP_BCLR:     result_ff <= operand_ff & ~(8'h01 << instr_ff[11:9]);
        default:         result_ff <= operand_ff;
      endcase
    end
  end

  // Accumulator
  always_ff @(posedge clk) begin
    if (srst) begin
      acc_ff <= `ABX_RST_ACC;
    end else if (state_ff == ABX_ST_Q4 && (op == ABX_OP_AND_LIT ||
                 (op == ABX_OP_AND_FILE && !instr_ff[9]))) begin
      acc_ff <= result_ff;
    end else if (sw_wr && wb_adr_i == `ABX_OFF_ACC && wb_sel_i[0]) begin
      acc_ff <= wb_dat_i[7:0];
    end
  end

  // Status: only the and operations touch N and Z
  always_ff @(posedge clk) begin
    if (srst) begin
      status_ff <= `ABX_RST_STATUS;
    end else if (state_ff == ABX_ST_Q4 && (op == ABX_OP_AND_LIT || op == ABX_OP_AND_FILE)) begin
      status_ff[`ABX_ST_N] <= result_ff[7];
      status_ff[`ABX_ST_Z] <= (result_ff == 8'h00);
    end else if (sw_wr && wb_adr_i == `ABX_OFF_STATUS && wb_sel_i[0]) begin
      status_ff <= wb_dat_i[7:0];
    end
  end

  // Program counter: step in Q1, branch target in Q4
  always_ff @(posedge clk) begin
    if (srst) begin
      pc_ff <= `ABX_RST_PC;
    end else if (state_ff == ABX_ST_Q1) begin
      pc_ff <= pc_ff + `ABX_PC_STEP;
    end else if (state_ff == ABX_ST_Q4 && taken) begin
      pc_ff <= nxt_target;
    end else if (sw_wr && wb_adr_i == `ABX_OFF_PC) begin
      pc_ff <= 21'(merge({11'h000, pc_ff}, wb_dat_i, wb_sel_i));
    end
  end

  // Software-side configuration
  always_ff @(posedge clk) begin
    if (srst) begin
      bank_ff    <= `ABX_RST_BANK;
      ext_ff     <= `ABX_RST_CTRL;
      idxbase_ff <= `ABX_RST_IDXBASE;
      faddr_ff   <= `ABX_RST_FADDR;
    end else if (sw_wr) begin
      if (wb_adr_i == `ABX_OFF_BANK && wb_sel_i[0]) begin
        bank_ff <= wb_dat_i[3:0];
      end
      if (wb_adr_i == `ABX_OFF_CTRL && wb_sel_i[0]) begin
        ext_ff <= wb_dat_i[`ABX_CTRL_EXT];
      end
      if (wb_adr_i == `ABX_OFF_IDXBASE) begin
        idxbase_ff <= 12'(merge({20'h00000, idxbase_ff}, wb_dat_i, wb_sel_i));
      end
      if (wb_adr_i == `ABX_OFF_FADDR) begin
        faddr_ff <= 12'(merge({20'h00000, faddr_ff}, wb_dat_i, wb_sel_i));
      end
    end
  end

  // File memory has no reset; software seeds it through the data window
  always_ff @(posedge clk) begin
    if (state_ff == ABX_ST_Q4 && (op == ABX_OP_BCLR ||
        (op == ABX_OP_AND_FILE && instr_ff[9]))) begin
      file_mem[fa] <= result_ff;
    end else if (!srst && sw_wr && wb_adr_i == `ABX_OFF_FDATA && wb_sel_i[0]) begin
      file_mem[faddr_ff] <= wb_dat_i[7:0];
    end
  end

  always_comb begin
    case (wb_adr_i)
      `ABX_OFF_INSTR:   rd_mux = {16'h0000, instr_ff};
      `ABX_OFF_ACC:     rd_mux = {24'h000000, acc_ff};
      `ABX_OFF_STATUS:  rd_mux = {23'h000000, exec_busy, status_ff};
      `ABX_OFF_BANK:    rd_mux = {28'h0000000, bank_ff};
      `ABX_OFF_PC:      rd_mux = {11'h000, pc_ff};
      `ABX_OFF_CTRL:    rd_mux = {31'h00000000, ext_ff};
      `ABX_OFF_IDXBASE: rd_mux = {20'h00000, idxbase_ff};
      `ABX_OFF_FADDR:   rd_mux = {20'h00000, faddr_ff};
      `ABX_OFF_FDATA:   rd_mux = {24'h000000, file_mem[faddr_ff]};
      default:          rd_mux = 32'h00000000;
    endcase
  end

  // Every request gets ack one cycle later, mapped or not
  always_ff @(posedge clk) begin
    if (srst) begin
      ack_ff <= 1'b0;
      dat_ff <= 32'h00000000;
    end else begin
      ack_ff <= bus_req;
      if (bus_req && !wb_we_i) begin
        dat_ff <= rd_mux;
      end
    end
  end

  chk_andf_flags: assert property (@(posedge clk) disable iff (srst)
    (state_ff == ABX_ST_Q4 && op == ABX_OP_AND_FILE) |=>
      status_ff[`ABX_ST_Z] == ($past(acc_ff & operand_ff) == 8'h00) &&
      status_ff[`ABX_ST_N] == $past(acc_ff[7] & operand_ff[7]))
    else $error("and with file flags wrong");
  chk_dest_acc: assert property (@(posedge clk) disable iff (srst)
    (state_ff == ABX_ST_Q4 && op == ABX_OP_AND_FILE && !instr_ff[9]) |=>
      acc_ff == $past(result_ff) && file_mem[$past(fa)] == $past(file_mem[fa]))
    else $error("destination select wrong");
  chk_bank_addr: assert property (@(posedge clk) disable iff (srst)
    (state_ff == ABX_ST_Q2 && instr_ff[8]) |-> fa == {bank_ff, instr_ff[7:0]})
    else $error("banked address wrong");
  chk_indexed_addr: assert property (@(posedge clk) disable iff (srst)
    (state_ff == ABX_ST_Q2 && !instr_ff[8] && ext_ff && instr_ff[7:0] <= `ABX_ACCESS_SPLIT) |->
      fa == idxbase_ff + {4'h0, instr_ff[7:0]})
    else $error("indexed address wrong");

  chk_brc_flags: assert property (@(posedge clk) disable iff (srst)
    (state_ff == ABX_ST_Q1 && op == ABX_OP_BRC) |-> ##4 $stable(status_ff) && 
      (exec_busy == $past(status_ff[`ABX_ST_C], 4)))
    else $error("branch on carry misbehaved");

  chk_branch_target: assert property (@(posedge clk) disable iff (srst)
    (state_ff == ABX_ST_Q4 && taken) |=>
      pc_ff == $past(pc_ff) + {{12{instr_ff[7]}}, instr_ff[7:0], 1'b0})
    else $error("branch target wrong");
  chk_branch_time: assert property (@(posedge clk) disable iff (srst)
    (state_ff == ABX_ST_Q4 && taken) |=> exec_busy [*4] ##1 !exec_busy)
    else $error("taken branch cycle count wrong");
  chk_untaken_time: assert property (@(posedge clk) disable iff (srst)
    (state_ff == ABX_ST_Q4 && op == ABX_OP_BRC && !taken) |=> !exec_busy && $stable(pc_ff))
    else $error("untaken branch cycle count wrong");
  chk_bit_clear: assert property (@(posedge clk) disable iff (srst)
    (state_ff == ABX_ST_Q4 && op == ABX_OP_BCLR) |=>
      file_mem[$past(fa)] == ($past(operand_ff) & ~(8'h01 << $past(instr_ff[11:9]))) &&
      $stable(status_ff))
    else $error("bit clear wrong");
  chk_and_literal: assert property (@(posedge clk) disable iff (srst)
    (state_ff == ABX_ST_Q1 && op == ABX_OP_AND_LIT) |-> ##4
      acc_ff == ($past(acc_ff, 4) & instr_ff[7:0]) && !exec_busy)
    else $error("and with literal wrong");

endmodule

/* File: verification/test_abx_core.sv */
/*
  Self-checking bench for abx_core: classic Wishbone accesses that load
  operands, start instructions and read back results and flags; busy timing is taken from the port.
  Assumes the core, its package and abx_map.svh are compiled first.
*/
`timescale 1ns/1ns
`include "abx_map.svh"

module test_abx_core;
  import abx_pkg::*;

  logic        clk;
  logic        srst;
  logic [7:0]  wb_adr_i;
  logic [31:0] wb_dat_i;
  logic [31:0] wb_dat_o;
  logic        wb_we_i;
  logic [3:0]  wb_sel_i;
  logic        wb_stb_i;
  logic        wb_cyc_i;
  logic        wb_ack_o;
  logic        exec_busy;
  int          err_count;
  int          n_tests;
  int          busy_cyc = 0;
  logic [31:0] rd_q;

  abx_core uut (
    .clk       (clk),
    .srst      (srst),
    .wb_adr_i  (wb_adr_i),
    .wb_dat_i  (wb_dat_i),
    .wb_dat_o  (wb_dat_o),
    .wb_we_i   (wb_we_i),
    .wb_sel_i  (wb_sel_i),
    .wb_stb_i  (wb_stb_i),
    .wb_cyc_i  (wb_cyc_i),
    .wb_ack_o  (wb_ack_o),
    .exec_busy (exec_busy)
  );

  initial begin
    clk = 1'b0;
    forever #50 clk = ~clk;
  end

  // Busy time measured from the port, not from polled status reads
  always @(posedge clk) begin
    if (exec_busy === 1'b1) begin
      busy_cyc <= busy_cyc + 1;
    end
  end

  task automatic tally_and_finish();
    $display("checks %0d mismatches %0d", n_tests, err_count);
    if (err_count == 0 && n_tests > 0) begin
      $display("*** PASS ***");
    end else begin
      $display("*** FAIL ***");
    end
    $finish;
  endtask

  task automatic chk(input logic [31:0] got, input logic [31:0] exp);
    n_tests++;
    if (got !== exp) begin
      err_count++;
      $display("CHECK FAILED t=%0t got=%h exp=%h", $time, got, exp);
    end
  endtask

  // One classic cycle; held until ack is sampled high
  task automatic xfer(input logic [7:0] a, input logic [31:0] d, input logic we);
    int i;
    @(posedge clk);
    wb_adr_i <= a;
    wb_dat_i <= d;
    wb_we_i  <= we;
    wb_sel_i <= 4'hF;
    wb_cyc_i <= 1'b1;
    wb_stb_i <= 1'b1;
    for (i = 0; i < 50; i++) begin
      @(posedge clk);
      if (wb_ack_o === 1'b1) break;
    end
    rd_q = wb_dat_o;
    wb_cyc_i <= 1'b0;
    wb_stb_i <= 1'b0;
    wb_we_i  <= 1'b0;
    if (i == 50) begin
      err_count++;
      tally_and_finish();
    end
  endtask

  task automatic wr(input logic [7:0] a, input logic [31:0] d);
    xfer(a, d, 1'b1);
  endtask

  task automatic rdc(input logic [7:0] a, input logic [31:0] exp);
    xfer(a, 32'h00000000, 1'b0);
    chk(rd_q, exp);
  endtask

  // Start an instruction, wait for idle, check busy length
  task automatic exec(input logic [15:0] ins, input int cyc_exp);
    int i;
    int c0;
    c0 = busy_cyc;
    wr(`ABX_OFF_INSTR, {16'h0000, ins});
    for (i = 0; i < 30; i++) begin
      @(posedge clk);
      if (exec_busy === 1'b0) break;
    end
    @(negedge clk);
    if (i == 30) begin
      err_count++;
      tally_and_finish();
    end
    chk(busy_cyc - c0, cyc_exp);
  endtask

  logic [7:0]  br_st [4] = '{8'h15, 8'h14, 8'h01, 8'h11};
  logic [7:0]  br_n  [4] = '{8'h05, 8'h05, 8'h80, 8'h7F};
  logic [20:0] br_pc [4] = '{21'h00010C, 21'h000102, 21'h000002, 21'h000200};
  int          br_cy [4] = '{8, 4, 8, 8};

  initial begin
    srst = 1'b1;
    wb_adr_i = 8'h00;
    wb_dat_i = 32'h00000000;
    wb_we_i = 1'b0;
    wb_sel_i = 4'h0;
    wb_stb_i = 1'b0;
    wb_cyc_i = 1'b0;
    err_count = 0;
    n_tests = 0;
    repeat (20) @(posedge clk);
    srst <= 1'b0;
    rdc(`ABX_OFF_ACC, 32'h00000000);
    rdc(`ABX_OFF_STATUS, 32'h00000000);
    rdc(`ABX_OFF_PC, 32'h00000000);
    rdc(8'h30, 32'h00000000);
    $display("test reset done");
    wr(`ABX_OFF_STATUS, 32'h00000001);
    wr(`ABX_OFF_ACC, 32'h000000A3);
    exec(16'h0B5F, 4);
    rdc(`ABX_OFF_ACC, 32'h00000003);
    rdc(`ABX_OFF_STATUS, 32'h00000001);
    exec(16'h0B00, 4);
    rdc(`ABX_OFF_STATUS, 32'h00000005);
    wr(`ABX_OFF_ACC, 32'h00000080);
    exec(16'h0B80, 4);
    rdc(`ABX_OFF_STATUS, 32'h00000011);
    $display("test literal and done");
    wr(`ABX_OFF_BANK, 32'h00000003);
    wr(`ABX_OFF_FADDR, 32'h000003C2);
    wr(`ABX_OFF_FDATA, 32'h000000C2);
    wr(`ABX_OFF_ACC, 32'h00000017);
    exec(16'h15C2, 4);
    rdc(`ABX_OFF_ACC, 32'h00000002);
    rdc(`ABX_OFF_FDATA, 32'h000000C2);
    rdc(`ABX_OFF_STATUS, 32'h00000001);
    exec(16'h17C2, 4);
    rdc(`ABX_OFF_FDATA, 32'h00000002);
    wr(`ABX_OFF_FADDR, 32'h00000020);
    wr(`ABX_OFF_FDATA, 32'h0000000F);
    wr(`ABX_OFF_ACC, 32'h000000FF);
    exec(16'h1420, 4);
    rdc(`ABX_OFF_ACC, 32'h0000000F);
    wr(`ABX_OFF_FADDR, 32'h00000F80);
    wr(`ABX_OFF_FDATA, 32'h000000F0);
    exec(16'h1680, 4);
    rdc(`ABX_OFF_FDATA, 32'h00000000);
    rdc(`ABX_OFF_STATUS, 32'h00000005);
    $display("test file and done");
    wr(`ABX_OFF_CTRL, 32'h00000001);
    wr(`ABX_OFF_IDXBASE, 32'h00000100);
    wr(`ABX_OFF_FADDR, 32'h0000015F);
    wr(`ABX_OFF_FDATA, 32'h0000003C);
    wr(`ABX_OFF_ACC, 32'h000000FF);
    exec(16'h145F, 4);
    rdc(`ABX_OFF_ACC, 32'h0000003C);
    wr(`ABX_OFF_FADDR, 32'h00000F60);
    wr(`ABX_OFF_FDATA, 32'h00000055);
    exec(16'h1460, 4);
    rdc(`ABX_OFF_ACC, 32'h00000014);
    wr(`ABX_OFF_CTRL, 32'h00000000);
    $display("test indexed done");
    // Taken, untaken and both offset extremes
    for (int k = 0; k < 4; k++) begin
      wr(`ABX_OFF_PC, 32'h00000100);
      wr(`ABX_OFF_STATUS, {24'h000000, br_st[k]});
      exec({8'hE2, br_n[k]}, br_cy[k]);
      rdc(`ABX_OFF_PC, {11'h000, br_pc[k]});
      rdc(`ABX_OFF_STATUS, {24'h000000, br_st[k]});
    end
    $display("test branch done");
    wr(`ABX_OFF_FADDR, 32'h00000340);
    for (int b = 0; b < 8; b++) begin
      wr(`ABX_OFF_FDATA, 32'h000000FF);
      exec(16'h9140 | (16'(b) << 9), 4);
      rdc(`ABX_OFF_FDATA, {24'h000000, ~(8'h01 << b)});
    end
    rdc(`ABX_OFF_STATUS, 32'h00000011);
    $display("test bit clear done");
    // A status write landing mid-instruction is acked but dropped, so C survives
    wr(`ABX_OFF_INSTR, 32'h00000B00);
    wr(`ABX_OFF_STATUS, 32'h00000000);
    rdc(`ABX_OFF_ACC, 32'h00000000);
    rdc(`ABX_OFF_STATUS, 32'h00000005);
    $display("test busy write done");
    tally_and_finish();
  end
endmodule
